// file: core/racw_pkg.sv
package racw_pkg;

	// Register map, byte addresses on the 32-bit bus
	localparam logic [11:0] MISC_CTRL_OFFSET   = 12'h00c;
	localparam logic [11:0] RESET_STATUS_OFFSET = 12'h010;

	// Field positions in the shared control register
	localparam int POR_FLAG_BIT = 7;
	localparam int WATCHDOG_ENABLE_BIT_EN_BIT  = 0;

	// Reset cause codes shown in the status register
	localparam logic [1:0] CAUSE_POWER_ON = 2'h0;
	localparam logic [1:0] CAUSE_EXTERNAL = 2'h1;
	localparam logic [1:0] CAUSE_WATCHDOG = 2'h2;
	localparam logic [1:0] CAUSE_HALT     = 2'h3;

	// Start vector location fetched after every reset
	localparam logic [15:0] START_VECTOR_ADDR = 16'h1ffe;

	// Start-up delay lengths, in machine cycles
	localparam int STARTUP_SHORT_CYC = 16;
	localparam int STARTUP_LONG_CYC  = 4064;

	// One machine cycle is one pclk period at 100 MHz
	localparam int CLK_PERIOD_NS = 10;
	localparam int MACHINE_CYCLE_NS = 10;
	localparam int MCYC_CLKS = (MACHINE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Least time the pin must read low before a watchdog reset lets go
	localparam int WATCHDOG_ENABLE_BIT_HOLD_NS = 160;
	localparam int WATCHDOG_ENABLE_BIT_HOLD_CLKS = (WATCHDOG_ENABLE_BIT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Watchdog chain stages
	localparam int PRE_A_DIV = 4;
	localparam int PRE_B_DIV = 256;
	localparam logic [2:0] WATCHDOG_ENABLE_BIT_FINAL = 3'h7;

	// Values after reset
	localparam logic [1:0] PRE_A_RESET = 2'h0;
	localparam logic [7:0] PRE_B_RESET = 8'h00;
	localparam logic [2:0] WATCHDOG_ENABLE_BIT_RESET  = 3'h0;

	// Shared control register image
	typedef struct packed {
		logic       por_flag;
		logic [5:0] reserved;
		logic       watchdog_enable_bit_en;
	} racw_misc_t;

	// Reset-pin signals at the design boundary
	typedef struct packed {
		logic drive_low;
		logic oe_n;
	} racw_pin_t;

endpackage

// file: core/racw_reset_watchdog.sv
// How it works
// - Three reset sources; start vector, mask set
// - After start-up, wait for pin high
// - Start-up delay is 16 or 4064 cycles
// - Drive pin low during start-up delay
// - Power-on sets flag; zero write clears
// - Enable bit resets to build option
// - Resume on cycle after pin rises
// - Internal reset pulls pin open-drain low
// - Divide by 4, 256, then 8
// - Chain clocked by timer bit-7 carry
// - Enabled by option or software one
// - Software cannot disable the watchdog
// - Writing one clears the watchdog counter
// - Watchdog reset restores the option value
// - Seven counter clocks reach final state
// - Release pin after low hold time
// - Halt while enabled causes watchdog reset
// - Halt reset skips start-up, oscillator runs
// - Wait-mode watchdog behaviour is an option
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module racw_reset_watchdog #(
	parameter bit WATCHDOG_ENABLE_BIT_ON_AT_RESET = 1'b0,
	parameter bit LONG_STARTUP     = 1'b1,
	parameter bit WATCHDOG_ENABLE_BIT_RUNS_IN_WAIT = 1'b1,
	parameter int STARTUP_CYC      = LONG_STARTUP ? racw_pkg::STARTUP_LONG_CYC
	                                              : racw_pkg::STARTUP_SHORT_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        reset_pin_in,
	output logic             reset_pin_out,
	output logic             reset_pin_oe_n,
	input  wire logic        timer_bit7_carry,
	input  wire logic        halt_request,
	input  wire logic        wait_mode,
	output logic             core_reset_n,
	output logic             halt_grant,
	output logic             int_mask_set,
	output logic      [15:0] start_vector_addr
);

	// Phases of the reset sequencer
	typedef enum logic [1:0] {
		RACW_STARTUP,
		RACW_PIN_WAIT,
		RACW_WATCHDOG_ENABLE_BIT_HOLD,
		RACW_RUN
	} racw_state_t;

	localparam int STARTUP_W = $clog2(STARTUP_CYC + 1);
	localparam int HOLD_W    = $clog2(racw_pkg::WATCHDOG_ENABLE_BIT_HOLD_CLKS + 1);
	localparam int MCYC_W    = $clog2(racw_pkg::MCYC_CLKS + 1);

	racw_state_t          state;
	racw_pkg::racw_misc_t  misc;
	logic [1:0]           reset_cause;
	logic [STARTUP_W-1:0] startup_cnt;
	logic [HOLD_W-1:0]    hold_cnt;
	logic [MCYC_W-1:0]    resume_cnt;
	logic [1:0]           pre_a;
	logic [7:0]           pre_b;
	logic [2:0]           watchdog_enable_bit_cnt;
	logic                 pin_meta;
	logic                 pin_sync;
	logic                 pin_drive;
	logic                 wr_misc;
	logic                 setup_phase;
	logic                 mapped;
	logic                 pre_a_wrap;
	logic                 pre_b_wrap;
	logic                 watchdog_enable_bit_tick;
	logic                 watchdog_enable_bit_hold_clear;
	logic                 watchdog_enable_bit_timeout;
	logic                 halt_trip;
	logic                 watchdog_enable_bit_fire;
	logic                 ext_fire;
	logic                 software_kick;

	// One word compare, shared by decode, write strobe and read mux
	// Only the low twelve address bits decode; the block aliases above them
	function automatic logic hits(input logic [31:0] addr, input logic [11:0] offset);
		hits = (addr[11:0] == offset);
	endfunction

	// Decode for the two mapped words; anything else answers with an error
	function automatic logic is_mapped(input logic [31:0] addr);
		is_mapped = hits(addr, racw_pkg::MISC_CTRL_OFFSET) ||
		            hits(addr, racw_pkg::RESET_STATUS_OFFSET);
	endfunction

	// Pin passes two flops; nothing reads pin_meta but pin_sync
	// Reset low matches the pin, which is pulled low during start-up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
		end else begin
			pin_meta <= reset_pin_in;
			pin_sync <= pin_meta;
		end
	end

	// APB handshakes, zero wait states
	// Every register answers at the first access edge
	assign setup_phase = psel && !penable;
	assign mapped      = is_mapped(paddr);
	assign pready      = 1'b1;
	assign pslverr     = psel && penable && !mapped;
	assign wr_misc     = psel && penable && pwrite &&
	                     hits(paddr, racw_pkg::MISC_CTRL_OFFSET);

	// Write of one to the enable bit kicks the counter
	assign software_kick = wr_misc && pwdata[racw_pkg::WATCHDOG_ENABLE_BIT_EN_BIT];

	// Read data captured in the setup cycle so it comes from a flop
	// Pready stays high, so the access edge always finds it settled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase) begin
			if (hits(paddr, racw_pkg::MISC_CTRL_OFFSET)) begin
				prdata <= {24'h000000, misc};
			end else if (hits(paddr, racw_pkg::RESET_STATUS_OFFSET)) begin
				prdata <= {24'h000000, pin_sync, watchdog_enable_bit_cnt, 2'h0, reset_cause};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// Prescaler chain fed only by the timer carry, no other clock
	assign pre_a_wrap = timer_bit7_carry &&
	                    (pre_a == 2'(racw_pkg::PRE_A_DIV - 1));
	assign pre_b_wrap = pre_a_wrap &&
	                    (pre_b == 8'(racw_pkg::PRE_B_DIV - 1));

	// Wait mode may freeze and clear the divide-by-8 stage
	assign watchdog_enable_bit_hold_clear = wait_mode && !WATCHDOG_ENABLE_BIT_RUNS_IN_WAIT;

	assign watchdog_enable_bit_tick = pre_b_wrap && misc.watchdog_enable_bit_en && (state == RACW_RUN) &&
	                   !watchdog_enable_bit_hold_clear;

	// Fixed prescalers free-run; only the last stage is software cleared
	// Kicks leave them alone, so a timeout may come up to one step early
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_a <= racw_pkg::PRE_A_RESET;
			pre_b <= racw_pkg::PRE_B_RESET;
		end else if (timer_bit7_carry) begin
			pre_a <= pre_a + 2'h1;
			if (pre_a_wrap) begin
				pre_b <= pre_b + 8'h01;
			end
		end
	end

	// Divide-by-8 stage; reaching seven trips the reset
	// Held clear outside the running state so each reset starts fresh
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_enable_bit_cnt <= racw_pkg::WATCHDOG_ENABLE_BIT_RESET;
		end else if (state != RACW_RUN || software_kick || watchdog_enable_bit_hold_clear) begin
			watchdog_enable_bit_cnt <= racw_pkg::WATCHDOG_ENABLE_BIT_RESET;
		end else if (watchdog_enable_bit_tick) begin
			watchdog_enable_bit_cnt <= watchdog_enable_bit_cnt + 3'h1;
		end
	end

	assign watchdog_enable_bit_timeout = (watchdog_enable_bit_cnt == racw_pkg::WATCHDOG_ENABLE_BIT_FINAL);

	// Halt with the watchdog on is turned into a watchdog reset
	// Pin low while the block pulls it is not an external reset
	assign halt_trip = halt_request && misc.watchdog_enable_bit_en && (state == RACW_RUN);
	assign watchdog_enable_bit_fire = (watchdog_enable_bit_timeout || halt_trip) && (state == RACW_RUN);
	assign ext_fire  = !pin_sync && (state == RACW_RUN) && !pin_drive;

	// Halt is granted only while the watchdog is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_grant <= 1'b0;
		end else begin
			halt_grant <= halt_request && !misc.watchdog_enable_bit_en && (state == RACW_RUN);
		end
	end

	// Control register; power-on flag set only by the async reset
	// Enable reload beats a kick in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			misc.por_flag <= 1'b1;
			misc.reserved <= 6'h00;
			misc.watchdog_enable_bit_en  <= WATCHDOG_ENABLE_BIT_ON_AT_RESET;
		end else begin
			if (watchdog_enable_bit_fire || ext_fire) begin
				misc.watchdog_enable_bit_en <= WATCHDOG_ENABLE_BIT_ON_AT_RESET;
			end else if (software_kick) begin
				misc.watchdog_enable_bit_en <= 1'b1;
			end
			// A zero write never lowers the enable bit
			if (wr_misc && !pwdata[racw_pkg::POR_FLAG_BIT]) begin
				misc.por_flag <= 1'b0;
			end
		end
	end

	// Reset sequencer: start-up, pin wait, watchdog hold, running
	// Watchdog resets skip the start-up delay and go straight to hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= RACW_STARTUP;
		end else begin
			unique case (state)
				RACW_STARTUP: begin
					if (startup_cnt == STARTUP_W'(STARTUP_CYC - 1)) begin
						state <= RACW_PIN_WAIT;
					end
				end
				RACW_PIN_WAIT: begin
					if (pin_sync && resume_cnt == MCYC_W'(racw_pkg::MCYC_CLKS - 1)) begin
						state <= RACW_RUN;
					end
				end
				RACW_WATCHDOG_ENABLE_BIT_HOLD: begin
					if (hold_cnt == HOLD_W'(racw_pkg::WATCHDOG_ENABLE_BIT_HOLD_CLKS)) begin
						state <= RACW_PIN_WAIT;
					end
				end
				RACW_RUN: begin
					if (watchdog_enable_bit_fire) begin
						state <= RACW_WATCHDOG_ENABLE_BIT_HOLD;
					end else if (ext_fire) begin
						state <= RACW_PIN_WAIT;
					end
				end
			endcase
		end
	end

	// Start-up delay counter, runs once after power-on only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			startup_cnt <= '0;
		end else if (state == RACW_STARTUP) begin
			startup_cnt <= startup_cnt + STARTUP_W'(1);
		end
	end

	// Hold time counts only cycles where the pin reads back low
	// A pin seen high restarts the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt <= '0;
		end else if (state != RACW_WATCHDOG_ENABLE_BIT_HOLD) begin
			hold_cnt <= '0;
		end else if (!pin_sync) begin
			hold_cnt <= hold_cnt + HOLD_W'(1);
		end else begin
			hold_cnt <= '0;
		end
	end

	// Resume delay: one machine cycle of pin high before running
	// One machine cycle is one clock here, so this is a single flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resume_cnt <= '0;
		end else if (state == RACW_PIN_WAIT && pin_sync) begin
			if (resume_cnt != MCYC_W'(racw_pkg::MCYC_CLKS - 1)) begin
				resume_cnt <= resume_cnt + MCYC_W'(1);
			end
		end else begin
			resume_cnt <= '0;
		end
	end

	// Reset cause, recorded when a reset starts
	// Watchdog and halt win over a pin event in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_cause <= racw_pkg::CAUSE_POWER_ON;
		end else if (watchdog_enable_bit_fire) begin
			reset_cause <= halt_trip ? racw_pkg::CAUSE_HALT : racw_pkg::CAUSE_WATCHDOG;
		end else if (ext_fire) begin
			reset_cause <= racw_pkg::CAUSE_EXTERNAL;
		end
	end

	// Open-drain pull-down, only for internal resets
	// Released as the hold count ends, in step with the sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_drive <= 1'b1;
		end else if (state == RACW_STARTUP) begin
			pin_drive <= (startup_cnt != STARTUP_W'(STARTUP_CYC - 1));
		end else if (state == RACW_RUN) begin
			pin_drive <= watchdog_enable_bit_fire;
		end else if (state == RACW_WATCHDOG_ENABLE_BIT_HOLD) begin
			pin_drive <= (hold_cnt != HOLD_W'(racw_pkg::WATCHDOG_ENABLE_BIT_HOLD_CLKS));
		end else begin
			pin_drive <= 1'b0;
		end
	end

	// Never drives high: the pin only sinks
	assign reset_pin_out  = 1'b0;
	assign reset_pin_oe_n = !pin_drive;

	// Core held in reset until running; mask pulse on the way out
	// Mask pulse leads core release by one clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reset_n <= 1'b0;
			int_mask_set <= 1'b0;
		end else begin
			core_reset_n <= (state == RACW_RUN) && !watchdog_enable_bit_fire && !ext_fire;
			int_mask_set <= (state == RACW_PIN_WAIT) && pin_sync &&
			                (resume_cnt == MCYC_W'(racw_pkg::MCYC_CLKS - 1));
		end
	end

	// Start vector address is fixed for every reset kind
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_vector_addr <= racw_pkg::START_VECTOR_ADDR;
		end else begin
			start_vector_addr <= racw_pkg::START_VECTOR_ADDR;
		end
	end

endmodule

`default_nettype wire

// file: verification/racw_props.sv
`timescale 1ns/100ps
`default_nettype none

module racw_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        reset_pin_in,
	input wire logic        reset_pin_out,
	input wire logic        reset_pin_oe_n,
	input wire logic        halt_request,
	input wire logic        halt_grant,
	input wire logic        core_reset_n,
	input wire logic        int_mask_set,
	input wire logic [15:0] start_vector_addr
);
	logic [4:0] low_cnt;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Run length of a low pin, saturating so it never wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			low_cnt <= 5'h00;
		else if (reset_pin_in)
			low_cnt <= 5'h00;
		else if (low_cnt != 5'h1f)
			low_cnt <= low_cnt + 5'h01;
	end

	bad_addr_a: assert property (psel && penable && paddr[11:0] != 12'h00c
		&& paddr[11:0] != 12'h010 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	start_vector_a: assert property (start_vector_addr == 16'h1ffe)
		else $error("start vector wrong");
	mask_pulse_a: assert property ($rose(core_reset_n) |-> $past(int_mask_set))
		else $error("left reset without mask pulse");
	startup_pull_a: assert property (!$past(presetn) |->
		!reset_pin_oe_n [*8] ##1 !reset_pin_oe_n [*7])
		else $error("pin released during start-up");
	pin_low_a: assert property (!reset_pin_in [*4] |=> !core_reset_n)
		else $error("core ran with pin low");
	open_drain_a: assert property (!reset_pin_oe_n |-> !reset_pin_out && !core_reset_n)
		else $error("pin pulled while core runs");
	hold_time_a: assert property ($rose(reset_pin_oe_n) |-> low_cnt >= 5'h0c)
		else $error("pin released too soon");
	halt_grant_a: assert property (halt_grant |-> $past(halt_request))
		else $error("halt granted without request");
endmodule

bind racw_reset_watchdog racw_props u_racw_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.prdata(prdata), .pslverr(pslverr), .reset_pin_in(reset_pin_in),
	.reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
	.halt_request(halt_request), .halt_grant(halt_grant), .core_reset_n(core_reset_n),
	.int_mask_set(int_mask_set), .start_vector_addr(start_vector_addr));
`default_nettype wire

// file: verification/racw_pin_partner.sv
`timescale 1ns/100ps
`default_nettype none

module racw_pin_partner (
	input wire logic oe_n,
	input wire logic ext_low,
	output logic     pin
);
	// Pull-up wins unless a party pulls low; nobody drives high
	assign pin = (!oe_n || ext_low) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic        carry = 1'b0, halt = 1'b0, waitm = 1'b0, ext_low = 1'b0, run_tmr = 1'b0;
	logic        pready, pslverr, pin, pin_out, oe_n, core_n, grant, mask, err;
	logic [15:0] vec;
	logic [31:0] prdata2, rd2;
	logic        pin2, oe2_n, core2_n;
	int          mismatches = 0, num_checks = 0;

	initial begin
		forever #5 pclk = ~pclk;
	end

	// Timer carry, one cycle in two
	always @(posedge pclk) carry <= run_tmr & ~carry;

	racw_reset_watchdog #(.LONG_STARTUP(1'b0)) u_racw_reset_watchdog (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reset_pin_in(pin), .reset_pin_out(pin_out), .reset_pin_oe_n(oe_n),
		.timer_bit7_carry(carry), .halt_request(halt), .wait_mode(waitm),
		.core_reset_n(core_n), .halt_grant(grant), .int_mask_set(mask),
		.start_vector_addr(vec));

	racw_pin_partner u_racw_pin_partner (.oe_n(oe_n), .ext_low(ext_low), .pin(pin));

	// Second build: watchdog on at reset, frozen and cleared in wait
	racw_reset_watchdog #(.LONG_STARTUP(1'b0), .WATCHDOG_ENABLE_BIT_ON_AT_RESET(1'b1),
		.WATCHDOG_ENABLE_BIT_RUNS_IN_WAIT(1'b0)) u_racw_reset_watchdog_opt (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata2), .pready(), .pslverr(),
		.reset_pin_in(pin2), .reset_pin_out(), .reset_pin_oe_n(oe2_n),
		.timer_bit7_carry(carry), .halt_request(halt), .wait_mode(waitm),
		.core_reset_n(core2_n), .halt_grant(), .int_mask_set(),
		.start_vector_addr());

	racw_pin_partner u_racw_pin_partner_opt (.oe_n(oe2_n), .ext_low(1'b0), .pin(pin2));

	task automatic end_sim;
		if (mismatches == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s exp %h got %h", nm, exp, got);
		end
	endtask

	// Setup then access; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {20'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		rd2 = prdata2;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask

	// Bounded wait for the core to leave reset
	task automatic wait_run(input int n);
		for (int i = 0; i < n && core_n !== 1'b1; i++) @(posedge pclk);
		chk("core_reset_n", 32'h1, {31'h0, core_n});
	endtask

	task automatic wait_fire(input int n);
		for (int i = 0; i < n && core_n !== 1'b0; i++) @(posedge pclk);
		chk("fired", 32'h0, {31'h0, core_n});
	endtask

	task automatic t_por;
		@(posedge pclk);
		#1 chk("por_pin", 32'h0, {31'h0, oe_n});
		wait_run(100);
		rdchk(12'h00c, 32'h80, "ctrl_por");
		chk("ctrl_opt", 32'h81, rd2);
		rdchk(12'h010, 32'h80, "stat_por");
		apb(1'b1, 12'h00c, 32'h0);
		rdchk(12'h00c, 32'h00, "por_clr");
		apb(1'b1, 12'h00c, 32'h80);
		rdchk(12'h00c, 32'h00, "por_no_set");
		apb(1'b0, 12'h020, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
	endtask

	// Kick mid-count, keep running in wait, then let it expire
	task automatic t_watchdog_enable_bit;
		apb(1'b1, 12'h00c, 32'h1);
		rdchk(12'h00c, 32'h01, "wd_on");
		apb(1'b1, 12'h00c, 32'h0);
		rdchk(12'h00c, 32'h01, "wd_keep");
		run_tmr <= 1'b1;
		repeat (10000) @(posedge pclk);
		apb(1'b1, 12'h00c, 32'h1);
		waitm <= 1'b1;
		repeat (12000) @(posedge pclk);
		chk("wd_early", 32'h1, {31'h0, core_n});
		wait_fire(3000);
		chk("wait_hold", 32'h1, {31'h0, core2_n});
		chk("wd_pin", 32'h0, {31'h0, oe_n});
		run_tmr <= 1'b0;
		waitm <= 1'b0;
		wait_run(200);
		rdchk(12'h00c, 32'h00, "wd_opt");
		rdchk(12'h010, 32'h82, "wd_cause");
	endtask

	task automatic t_halt;
		@(posedge pclk);
		halt <= 1'b1;
		@(posedge pclk);
		halt <= 1'b0;
		#1 chk("grant_off", 32'h1, {31'h0, grant});
		apb(1'b1, 12'h00c, 32'h1);
		@(posedge pclk);
		halt <= 1'b1;
		@(posedge pclk);
		halt <= 1'b0;
		#1 chk("grant_on", 32'h0, {31'h0, grant});
		wait_fire(5);
		wait_run(60);
		rdchk(12'h010, 32'h83, "halt_cause");
		rdchk(12'h00c, 32'h00, "halt_opt");
	endtask

	task automatic t_ext;
		ext_low <= 1'b1;
		repeat (6) @(posedge pclk);
		ext_low <= 1'b0;
		#1 chk("ext_core", 32'h0, {31'h0, core_n});
		chk("ext_oe", 32'h1, {31'h0, oe_n});
		wait_run(20);
		rdchk(12'h010, 32'h81, "ext_cause");
		rdchk(12'h00c, 32'h00, "ext_ctrl");
	endtask

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_por;
		t_watchdog_enable_bit;
		t_halt;
		t_ext;
		end_sim;
	end

	// Hang guard, well past the longest expected run
	initial begin
		#400000;
		mismatches++;
		end_sim;
	end
endmodule
`default_nettype wire
